// ==== verilog/bsfx_pkg.sv ====
// Package of constants, opcodes and status-flag positions for the execution unit
package bsfx_pkg;
    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] X_RESET = 16'h0000;
    // Cycle counts
    localparam int CYC_ONE = 1;
    localparam int CYC_TWO = 2;
    // Avalon register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_XPTR = 8'h10;
    localparam logic [7:0] REG_GPR_SEL = 8'h14;
    localparam logic [7:0] REG_GPR_DATA = 8'h18;
    localparam logic [7:0] REG_STATE = 8'h1C;
    localparam logic [7:0] REG_IO_SEL = 8'h20;
    localparam logic [7:0] REG_IO_DATA = 8'h24;
    localparam logic [7:0] REG_MEM_SEL = 8'h28;
    localparam logic [7:0] REG_MEM_DATA = 8'h2C;
    localparam logic [31:0] UNMAPPED_DATA = 32'hDEADBEEF;
    // Operation codes written to the instruction register bits 31:26
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_BRANCH_IRQ_ON = 6'h01,
        OP_BRANCH_IRQ_OFF = 6'h02,
        OP_IO_BIT_SET = 6'h03,
        OP_IO_BIT_CLEAR = 6'h04,
        OP_LOGIC_SHIFT_LEFT = 6'h05,
        OP_LOGIC_SHIFT_RIGHT = 6'h06,
        OP_ROTATE_LEFT_CARRY = 6'h07,
        OP_ROTATE_RIGHT_CARRY = 6'h08,
        OP_ARITH_SHIFT_RIGHT = 6'h09,
        OP_NIBBLE_SWAP = 6'h0A,
        OP_FLAG_INDEX_SET = 6'h0B,
        OP_FLAG_INDEX_CLEAR = 6'h0C,
        OP_BIT_TO_TRANSFER = 6'h0D,
        OP_TRANSFER_TO_BIT = 6'h0E,
        OP_COPY_BYTE = 6'h0F,
        OP_COPY_PAIR = 6'h10,
        OP_LOAD_CONSTANT = 6'h11,
        OP_INDIRECT_READ = 6'h12,
        OP_INDIRECT_READ_INC = 6'h13,
        OP_INDIRECT_READ_DEC = 6'h14
    } bsfx_op_type;
    // Execution state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SECOND = 2'b01
    } bsfx_state_type;
endpackage

// ==== verilog/bsfx_core.sv ====
// Execution unit for branch, bit, shift, flag and transfer operations
// Function
// - Branch when interrupts on, 1/2 cycles
// - Branch when interrupts off, 1/2 cycles
// - Set I/O bit, two cycles, no flags
// - Clear I/O bit, two cycles, no flags
// - Shift left, zero in, flags Z C N V
// - Shift right, zero in, flags Z C N V
// - Rotate left through carry, flags updated
// - Rotate right through carry, flags updated
// - Arithmetic shift right keeps sign bit
// - Swap nibbles, one cycle, no flags
// - Register bit into transfer flag only
// - Transfer flag into register bit
// - Set any status flag by index
// - Clear any status flag by index
// - Signed flag set and clear alone
// - Overflow flag set and clear alone
// - Indirect read then increment X
// - Decrement X then indirect read
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ns
module bsfx_core #(
    parameter int IO_DEPTH = 64,
    parameter int MEM_DEPTH = 256
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic BUSY_O
);
    import bsfx_pkg::*;

    // Architectural state
    logic [7:0] gpr_r [0:31];
    logic [7:0] io_r [0:IO_DEPTH-1];
    logic [7:0] mem_r [0:MEM_DEPTH-1];
    logic [7:0] status_r;
    logic [15:0] pc_r;
    logic [15:0] x_r;
    bsfx_state_type state_r;
    logic [31:0] instr_r;
    logic [4:0] gpr_sel_r;
    logic [7:0] io_sel_r;
    logic [15:0] mem_sel_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic [31:0] op_count_r;

    // Instruction fields: op[31:26] d[25:21] r[20:16] bit[10:8] io[7:0] imm[7:0] k[15:0]
    bsfx_op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [7:0] ioa;
    logic [7:0] imm;
    logic [15:0] koff;
    assign op = bsfx_op_type'(instr_r[31:26]);
    assign rd = instr_r[25:21];
    assign rr = instr_r[20:16];
    assign bsel = instr_r[10:8];
    assign ioa = instr_r[7:0];
    assign imm = instr_r[7:0];
    assign koff = instr_r[15:0];

    // Bus decode
    logic wr_go;
    logic rd_go;
    logic start;
    // Writes land at the edge where wait is low, reads are captured one edge earlier
    assign wr_go = AVS_WRITE_I && ack_r;
    assign rd_go = AVS_READ_I && !ack_r;
    assign start = wr_go && AVS_ADDRESS_I == REG_CTRL && AVS_WRITEDATA_I[0]
        && state_r == ST_IDLE;
    // Wait one cycle on every access, then release
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_r;
    assign BUSY_O = state_r != ST_IDLE;

    // Shift unit results and flags
    logic [7:0] src;
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_n;
    logic sh_v;
    logic sh_z;
    always_comb begin
        src = gpr_r[rd];
        sh_res = src;
        sh_c = status_r[FLAG_C];
        case (op)
            OP_LOGIC_SHIFT_LEFT: begin
                sh_res = {src[6:0], 1'b0};
                sh_c = src[7];
            end
            OP_LOGIC_SHIFT_RIGHT: begin
                sh_res = {1'b0, src[7:1]};
                sh_c = src[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                sh_res = {src[6:0], status_r[FLAG_C]};
                sh_c = src[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                sh_res = {status_r[FLAG_C], src[7:1]};
                sh_c = src[0];
            end
            OP_ARITH_SHIFT_RIGHT: begin
                sh_res = {src[7], src[7:1]};
                sh_c = src[0];
            end
            default: begin
                sh_res = src;
                sh_c = status_r[FLAG_C];
            end
        endcase
        sh_z = sh_res == 8'h00;
        sh_n = sh_res[7];
        sh_v = sh_n ^ sh_c;
    end

    // Is the current op a shift family op
    logic is_shift;
    assign is_shift = op == OP_LOGIC_SHIFT_LEFT || op == OP_LOGIC_SHIFT_RIGHT
        || op == OP_ROTATE_LEFT_CARRY || op == OP_ROTATE_RIGHT_CARRY
        || op == OP_ARITH_SHIFT_RIGHT;

    // Branch decision
    logic br_take;
    assign br_take = (op == OP_BRANCH_IRQ_ON && status_r[FLAG_I])
        || (op == OP_BRANCH_IRQ_OFF && !status_r[FLAG_I]);

    // Whether the op needs a second cycle
    logic two_cyc;
    assign two_cyc = br_take || op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR
        || op == OP_INDIRECT_READ || op == OP_INDIRECT_READ_INC
        || op == OP_INDIRECT_READ_DEC;

    // State machine: first cycle at start, optional second cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start && two_cyc) begin
                        state_r <= ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Counter of started operations for software visibility
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            op_count_r <= 32'h00000000;
        end else if (start) begin
            op_count_r <= op_count_r + 32'h00000001;
        end
    end

    // Program counter: advance by one, taken branch adds offset plus one
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            pc_r <= PC_RESET;
        end else if (wr_go && AVS_ADDRESS_I == REG_PC && state_r == ST_IDLE) begin
            pc_r <= AVS_WRITEDATA_I[15:0];
        end else if (state_r == ST_SECOND && br_take) begin
            pc_r <= pc_r + koff;
        end else if (start) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    // Status flags
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            status_r <= STATUS_RESET;
        end else if (wr_go && AVS_ADDRESS_I == REG_STATUS && state_r == ST_IDLE) begin
            status_r <= AVS_WRITEDATA_I[7:0];
        end else if (start) begin
            if (is_shift) begin
                status_r[FLAG_C] <= sh_c;
                status_r[FLAG_Z] <= sh_z;
                status_r[FLAG_N] <= sh_n;
                status_r[FLAG_V] <= sh_v;
            end else if (op == OP_FLAG_INDEX_SET) begin
                status_r[bsel] <= 1'b1;
            end else if (op == OP_FLAG_INDEX_CLEAR) begin
                status_r[bsel] <= 1'b0;
            end else if (op == OP_BIT_TO_TRANSFER) begin
                status_r[FLAG_T] <= gpr_r[rr][bsel];
            end
        end
    end

    // X pointer
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            x_r <= X_RESET;
        end else if (wr_go && AVS_ADDRESS_I == REG_XPTR && state_r == ST_IDLE) begin
            x_r <= AVS_WRITEDATA_I[15:0];
        end else if (start && op == OP_INDIRECT_READ_DEC) begin
            x_r <= x_r - 16'h0001;
        end else if (state_r == ST_SECOND && op == OP_INDIRECT_READ_INC) begin
            x_r <= x_r + 16'h0001;
        end
    end

    // Working registers
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_go && AVS_ADDRESS_I == REG_GPR_DATA && state_r == ST_IDLE) begin
            gpr_r[gpr_sel_r] <= AVS_WRITEDATA_I[7:0];
        end else if (start) begin
            case (op)
                OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
                OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
                    gpr_r[rd] <= sh_res;
                end
                OP_NIBBLE_SWAP: begin
                    gpr_r[rd] <= {src[3:0], src[7:4]};
                end
                OP_TRANSFER_TO_BIT: begin
                    gpr_r[rd][bsel] <= status_r[FLAG_T];
                end
                OP_COPY_BYTE: begin
                    gpr_r[rd] <= gpr_r[rr];
                end
                OP_COPY_PAIR: begin
                    gpr_r[{rd[4:1], 1'b0}] <= gpr_r[{rr[4:1], 1'b0}];
                    gpr_r[{rd[4:1], 1'b1}] <= gpr_r[{rr[4:1], 1'b1}];
                end
                OP_LOAD_CONSTANT: begin
                    gpr_r[{1'b1, rd[3:0]}] <= imm;
                end
                default: begin
                end
            endcase
        end else if (state_r == ST_SECOND) begin
            if (op == OP_INDIRECT_READ || op == OP_INDIRECT_READ_INC
                || op == OP_INDIRECT_READ_DEC) begin
                gpr_r[rd] <= mem_r[8'(x_r)];
            end
        end
    end

    // I/O space: read-modify-write completes on the second cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_go && AVS_ADDRESS_I == REG_IO_DATA && state_r == ST_IDLE) begin
            io_r[io_sel_r[5:0]] <= AVS_WRITEDATA_I[7:0];
        end else if (state_r == ST_SECOND && op == OP_IO_BIT_SET) begin
            io_r[ioa[5:0]][bsel] <= 1'b1;
        end else if (state_r == ST_SECOND && op == OP_IO_BIT_CLEAR) begin
            io_r[ioa[5:0]][bsel] <= 1'b0;
        end
    end

    // Data memory: loaded by software
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_go && AVS_ADDRESS_I == REG_MEM_DATA) begin
            mem_r[mem_sel_r[7:0]] <= AVS_WRITEDATA_I[7:0];
        end
    end

    // Instruction and selector registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            instr_r <= 32'h00000000;
            gpr_sel_r <= 5'h00;
            io_sel_r <= 8'h00;
            mem_sel_r <= 16'h0000;
        end else if (wr_go && state_r == ST_IDLE) begin
            case (AVS_ADDRESS_I)
                REG_INSTR: instr_r <= AVS_WRITEDATA_I;
                REG_GPR_SEL: gpr_sel_r <= AVS_WRITEDATA_I[4:0];
                REG_IO_SEL: io_sel_r <= AVS_WRITEDATA_I[7:0];
                REG_MEM_SEL: mem_sel_r <= AVS_WRITEDATA_I[15:0];
                default: begin
                end
            endcase
        end
    end

    // Bus acknowledge and read data
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= (AVS_READ_I || AVS_WRITE_I) && !ack_r;
            if (rd_go) begin
                case (AVS_ADDRESS_I)
                    REG_CTRL: rdata_r <= {31'h00000000, BUSY_O};
                    REG_INSTR: rdata_r <= instr_r;
                    REG_STATUS: rdata_r <= {24'h000000, status_r};
                    REG_PC: rdata_r <= {16'h0000, pc_r};
                    REG_XPTR: rdata_r <= {16'h0000, x_r};
                    REG_GPR_SEL: rdata_r <= {27'h0000000, gpr_sel_r};
                    REG_GPR_DATA: rdata_r <= {24'h000000, gpr_r[gpr_sel_r]};
                    REG_STATE: rdata_r <= op_count_r;
                    REG_IO_SEL: rdata_r <= {24'h000000, io_sel_r};
                    REG_IO_DATA: rdata_r <= {24'h000000, io_r[io_sel_r[5:0]]};
                    REG_MEM_SEL: rdata_r <= {16'h0000, mem_sel_r};
                    REG_MEM_DATA: rdata_r <= {24'h000000, mem_r[mem_sel_r[7:0]]};
                    default: rdata_r <= UNMAPPED_DATA;
                endcase
            end
        end
    end
    assign AVS_READDATA_O = rdata_r;
endmodule

// ==== verif/bsfx_shift_model.sv ====
// Reference model of shift, rotate and swap results with their flags
`timescale 1ns/1ns
module bsfx_shift_model
    import bsfx_pkg::*;
(
    input wire logic [5:0] op_i,
    input wire logic [7:0] val_i,
    input wire logic [7:0] sr_i,
    output logic [7:0] res_o,
    output logic [7:0] sr_o
);
    // Result, carry out and flag update for each shift and rotate; swap leaves the flags unchanged
    always_comb begin
        logic c;
        c = sr_i[FLAG_C];
        case (op_i)
            6'h05: {c, res_o} = {val_i, 1'b0};
            6'h06: {res_o, c} = {1'b0, val_i};
            6'h07: {c, res_o} = {val_i, sr_i[FLAG_C]};
            6'h08: {res_o, c} = {sr_i[FLAG_C], val_i};
            6'h09: {res_o, c} = {val_i[7], val_i};
            default: res_o = {val_i[3:0], val_i[7:4]};
        endcase
        sr_o = sr_i;
        if (op_i != 6'h0A) begin
            sr_o[FLAG_C] = c;
            sr_o[FLAG_Z] = (res_o == 8'h00);
            sr_o[FLAG_N] = res_o[7];
            sr_o[FLAG_V] = res_o[7] ^ c;
        end
    end
endmodule

// ==== verif/bsfx_core_monitor.sv ====
// Checker for bus handshake, read data and busy timing
`timescale 1ns/1ns
module bsfx_core_monitor
    import bsfx_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic BUSY_O
);
    default clocking dcb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Start command seen in the acknowledged cycle of a control write
    wire start = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == REG_CTRL
        && AVS_WRITEDATA_I[0];
    // Handshake steps
    sequence s_req_first;
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
    endsequence
    sequence s_ack;
        (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
    endsequence
    a_wait_first: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
        else $error("no wait in first request cycle");
    a_wait_once: assert property (s_req_first |=> s_ack)
        else $error("request not answered after one wait");
    a_idle_ready: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
        else $error("wait raised with no request");
    a_unmapped_read: assert property (s_ack ##0 AVS_READ_I && AVS_ADDRESS_I > 8'h2C
        |-> AVS_READDATA_O == UNMAPPED_DATA) else $error("bad unmapped read data");
    a_rdata_hold: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
        else $error("read data moved without a read");
    a_busy_cause: assert property ($rose(BUSY_O) |-> $past(start) || $past(start, 2))
        else $error("busy without a start");
    a_busy_single: assert property (BUSY_O |=> !BUSY_O)
        else $error("busy longer than one cycle");
    a_reset_clean: assert property ($rose(RSTN_I) |-> !BUSY_O && AVS_READDATA_O == 32'h00000000)
        else $error("state not clean after reset");
    c_start: cover property (start ##[1:2] BUSY_O);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench driving the execution unit over its register bus
`timescale 1ns/1ns
module tb_top;
    import bsfx_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic wreq;
    logic busy;
    logic [5:0] m_op;
    logic [7:0] m_val, m_sr, m_res, m_sro;
    int errors = 0;
    int checked = 0;
    int bcnt = 0;
    int cycles = 0;
    bsfx_core dut(.CORE_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_i),
        .AVS_WRITE_I(wr_i), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wreq), .BUSY_O(busy));
    bsfx_shift_model ref_m(.op_i(m_op), .val_i(m_val), .sr_i(m_sr), .res_o(m_res), .sr_o(m_sro));
    // Clock
    always #50 clk = ~clk;
    // Hang guard and busy cycle count
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    always @(negedge clk) if (busy === 1'b1) bcnt++;
    task report_and_stop;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus transfer held until the edge where wait is low
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_i <= w;
        rd_i <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        r = rdat;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        if (n >= 50) errors++;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        acc(1'b1, a, d, x);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        acc(1'b0, a, 32'h00000000, x);
        chk(x, e);
    endtask
    task gw(input logic [7:0] sa, input logic [7:0] i, input logic [7:0] v);
        wr(sa, {24'h000000, i});
        wr(sa + 8'h04, {24'h000000, v});
    endtask
    task gc(input logic [7:0] i, input logic [7:0] e);
        wr(REG_GPR_SEL, {24'h000000, i});
        rc(REG_GPR_DATA, {24'h000000, e});
    endtask
    task run(input logic [5:0] op, input logic [4:0] d, input logic [4:0] s,
        input logic [15:0] lo, input int eb);
        wr(REG_INSTR, {op, d, s, lo});
        bcnt = 0;
        wr(REG_CTRL, 32'h00000001);
        repeat (3) @(posedge clk);
        chk(bcnt, eb);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rc(REG_STATUS, 32'h00000000);
        rc(REG_XPTR, 32'h00000000);
        rc(8'h30, UNMAPPED_DATA);
        for (int i = 0; i < 12; i++) begin
            m_op = 6'(5 + i / 2);
            m_val = (i % 2) ? 8'h01 : 8'hC0;
            m_sr = (i % 2) ? 8'h70 : 8'h31;
            gw(REG_GPR_SEL, 8'h03, m_val);
            wr(REG_STATUS, {24'h000000, m_sr});
            run(m_op, 5'd3, 5'd0, 16'h0000, 0);
            gc(8'h03, m_res);
            rc(REG_STATUS, {24'h000000, m_sro});
        end
        for (int s = 0; s < 8; s++) begin
            wr(REG_STATUS, 32'h00000000);
            run(OP_FLAG_INDEX_SET, 5'd0, 5'd0, 16'(s << 8), 0);
            rc(REG_STATUS, 32'(1 << s));
            wr(REG_STATUS, 32'h000000FF);
            run(OP_FLAG_INDEX_CLEAR, 5'd0, 5'd0, 16'(s << 8), 0);
            rc(REG_STATUS, 32'(255 ^ (1 << s)));
        end
        gw(REG_GPR_SEL, 8'h04, 8'h20);
        gw(REG_GPR_SEL, 8'h06, 8'h00);
        wr(REG_STATUS, 32'h00000000);
        run(OP_BIT_TO_TRANSFER, 5'd0, 5'd4, 16'h0500, 0);
        rc(REG_STATUS, 32'h00000040);
        run(OP_TRANSFER_TO_BIT, 5'd6, 5'd0, 16'h0200, 0);
        gc(8'h06, 8'h04);
        wr(REG_STATUS, 32'h00000080);
        wr(REG_PC, 32'h00000010);
        run(OP_BRANCH_IRQ_ON, 5'd0, 5'd0, 16'h0005, 1);
        rc(REG_PC, 32'h00000016);
        run(OP_BRANCH_IRQ_OFF, 5'd0, 5'd0, 16'h0005, 0);
        rc(REG_PC, 32'h00000017);
        wr(REG_STATUS, 32'h00000000);
        run(OP_BRANCH_IRQ_OFF, 5'd0, 5'd0, 16'hFFFD, 1);
        rc(REG_PC, 32'h00000015);
        run(OP_BRANCH_IRQ_ON, 5'd0, 5'd0, 16'h0005, 0);
        rc(REG_PC, 32'h00000016);
        gw(REG_IO_SEL, 8'h05, 8'h5A);
        wr(REG_STATUS, 32'h000000A5);
        run(OP_IO_BIT_SET, 5'd0, 5'd0, 16'h0005, 1);
        rc(REG_IO_DATA, 32'h0000005B);
        run(OP_IO_BIT_CLEAR, 5'd0, 5'd0, 16'h0605, 1);
        rc(REG_IO_DATA, 32'h0000001B);
        gw(REG_GPR_SEL, 8'h01, 8'h3C);
        gw(REG_GPR_SEL, 8'h0A, 8'h11);
        gw(REG_GPR_SEL, 8'h0B, 8'h22);
        run(OP_COPY_BYTE, 5'd2, 5'd1, 16'h0000, 0);
        run(OP_COPY_PAIR, 5'd8, 5'd10, 16'h0000, 0);
        run(OP_LOAD_CONSTANT, 5'd16, 5'd0, 16'h00E7, 0);
        gc(8'h02, 8'h3C);
        gc(8'h08, 8'h11);
        gc(8'h09, 8'h22);
        gc(8'h10, 8'hE7);
        gw(REG_MEM_SEL, 8'h3F, 8'hCC);
        gw(REG_MEM_SEL, 8'h40, 8'hAA);
        gw(REG_MEM_SEL, 8'h41, 8'hBB);
        wr(REG_XPTR, 32'h00000040);
        run(OP_INDIRECT_READ, 5'd5, 5'd0, 16'h0000, 1);
        gc(8'h05, 8'hAA);
        rc(REG_XPTR, 32'h00000040);
        run(OP_INDIRECT_READ_INC, 5'd5, 5'd0, 16'h0000, 1);
        run(OP_INDIRECT_READ_INC, 5'd7, 5'd0, 16'h0000, 1);
        gc(8'h07, 8'hBB);
        rc(REG_XPTR, 32'h00000042);
        wr(REG_XPTR, 32'h00000040);
        run(OP_INDIRECT_READ_DEC, 5'd5, 5'd0, 16'h0000, 1);
        gc(8'h05, 8'hCC);
        rc(REG_XPTR, 32'h0000003F);
        rc(REG_STATUS, 32'h000000A5);
        rc(REG_STATE, 32'h0000002B);
        report_and_stop();
    end
endmodule
bind bsfx_core bsfx_core_monitor mon(.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .BUSY_O(BUSY_O));
